/* File: core/cbs_pkg.sv */
// Shared constants and carrier types for the buck sequencer
package cbs_pkg;
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
	localparam int unsigned MIN_OFF_NS    = 400;
	localparam int unsigned MIN_OFF_CYC   = (MIN_OFF_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned TON_OFFS_NS   = 50;
	localparam int unsigned TON_OFFS_CYC  = (TON_OFFS_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned NOC_WAIT_NS   = 2000;
	localparam int unsigned NOC_WAIT_CYC  = NOC_WAIT_NS / CLK_NS;
	localparam int unsigned NOC_PROBE_NS  = 300;
	localparam int unsigned NOC_PROBE_CYC = (NOC_PROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned DEGLITCH_NS   = 5000;
	localparam int unsigned DEGLITCH_CYC  = (DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SS_STEP_CYC   = 110;
	localparam int unsigned SS_TOTAL_CYC  = 4 * SS_STEP_CYC;
	localparam int unsigned TIMER_W       = 8;
	localparam int unsigned SS_W          = 9;
	localparam int unsigned SENSE_LAG_CYC = 3;
	localparam logic [7:0]  TON_RST       = 8'h10;
	localparam logic [1:0]  STEP_RST      = 2'h0;

	// Switching states
	typedef enum logic [2:0]
	{
		CBS_OFF     = 3'b000,
		CBS_BOOT    = 3'b001,
		CBS_LOW     = 3'b010,
		CBS_HIGH    = 3'b011,
		CBS_MINOFF  = 3'b100,
		CBS_NOCWAIT = 3'b101,
		CBS_NOCPROB = 3'b110
	} cbs_state_t;

	// Raw comparator and supply levels
	typedef struct packed
	{
		logic analogPor;
		logic analogUvloOk;
		logic driverSupplyOk;
		logic referenceInputOk;
		logic overVoltage;
		logic underVoltage;
		logic pgWindowOut;
		logic pgNinety;
		logic posOverCurrent;
		logic negOverCurrent;
		logic lowGateOff;
		logic phaseLow;
	} cbs_sense_t;

	// Drive outputs
	typedef struct packed
	{
		logic highSideGate;
		logic lowSideGate;
		logic gateTriState;
		logic limitSourceOn;
		logic bufferedReferenceOn;
		logic terminationOn;
		logic powerGoodOut;
		logic [1:0] limitStep;
		logic faultOv;
		logic faultUv;
	} cbs_drive_t;
endpackage

/* File: core/cbs_deglitch.sv */
// Two-stage synchroniser followed by a persistence filter
`timescale 1ns/1ps
module cbs_deglitch
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Level in and out
	input  wire logic levelIn,
	input  wire logic filterClr,
	output logic      levelSync,
	output logic      levelStable
);
	import cbs_pkg::*;

	typedef struct packed
	{
		logic                 meta;
		logic                 sync;
		logic [TIMER_W-1:0]   cnt;
		logic                 stable;
	} cbs_dg_t;

	cbs_dg_t st_r;
	cbs_dg_t st_nxt;

	always_comb
	begin
		st_nxt      = st_r;
		st_nxt.meta = levelIn;
		st_nxt.sync = st_r.meta;
		if (filterClr || st_r.sync == st_r.stable)
			st_nxt.cnt = '0;
		else if (st_r.cnt == TIMER_W'(DEGLITCH_CYC - 1))
		begin
			st_nxt.stable = st_r.sync;
			st_nxt.cnt    = '0;
		end
		else
			st_nxt.cnt = st_r.cnt + 1'b1;
		if (filterClr)
			st_nxt.stable = 1'b0;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign levelSync   = st_r.sync;
	assign levelStable = st_r.stable;
endmodule

/* File: core/cbs_sequencer.sv */
// Constant on-time buck sequencer with soft start and fault latches
//
// Operation
// - After each high-side pulse hold a minimum off-time of 400 ns.
// - High-side on-time from a one-shot; grows with output, shrinks with input, plus 50 ns.
// - Buffered reference on when reference input valid and analog supply present.
// - Termination output needs driver, analog and reference; driver loss keeps reference.
// - Limit-sense current source on only while low-side gate is on.
// - Positive over-current withholds the next high-side pulse until it clears.
// - Negative over-current: low side off, wait 2 us, probe 300 ns, repeat.
// - Power-good low until soft start done and output reaches 90 percent.
// - Power-good changes only after condition persists 5 us.
// - Overvoltage latches low side on and controller off until fault reset.
// - Overvoltage must persist 5 us before latching.
// - Undervoltage latches both gates tri-stated and controller off.
// - Undervoltage must persist 5 us before latching.
// - Fault latch clears only on analog supply or reference input toggle.
// - Power-on reset above 3 V; lockout inhibits switching and reference.
// - Lockout release enables reference, clears faults and soft-start timer.
// - Switching needs reference input, driver supply and analog supply.
// - First switching action after enable is a low-side pulse.
// - Soft start: four 110-pulse steps, 25 to 100 percent, first double off-time.
// - Undervoltage and power-good qualification enabled after fourth soft-start step.
// - Analog supply falling to lockout tri-states gates and disables reference.
// - High side waits for low gate off; low side waits for phase low.
`timescale 1ns/1ps
module cbs_sequencer
(
	// Clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rst,
	// Analog comparator and supply levels
	input  wire cbs_pkg::cbs_sense_t senseIn,
	// Error comparator: output below reference, request next on-pulse
	input  wire logic               feedbackLow,
	// On-time one-shot: capacitor reached output level
	input  wire logic               onTimeDone,
	// Gate and status outputs
	output cbs_pkg::cbs_drive_t     driveOut
);
	import cbs_pkg::*;

	typedef struct packed
	{
		cbs_state_t          state;
		logic [TIMER_W-1:0]  timer;
		logic [SS_W-1:0]     ssCount;
		logic                ssDone;
		logic                faultOv;
		logic                faultUv;
		logic                prevUvloOk;
		logic                prevRefOk;
		logic                lowRel;
		logic [5:0]          mSync1;
		logic [5:0]          mSync2;
		logic                fbSync1;
		logic                fbSync2;
		logic                tonSync1;
		logic                tonSync2;
		cbs_drive_t          drive;
	} cbs_seq_t;

	cbs_seq_t st_r;
	cbs_seq_t st_nxt;

	logic ovStable;
	logic uvStable;
	logic pgStable;
	logic ocSync;
	logic ncSync;
	logic pg90Sync;
	logic pgBadRaw;
	logic filterClr;

	// Synchronised supply and gate-feedback levels
	logic uvloOk;
	logic refOk;
	logic drvOk;
	logic lgOff;
	logic phLow;

	function automatic logic [TIMER_W-1:0] minOffFor(input logic [1:0] step);
		minOffFor = (step == 2'h0) ? TIMER_W'(2 * MIN_OFF_CYC) : TIMER_W'(MIN_OFF_CYC);
	endfunction

	// Soft-start step of a pulse count
	function automatic logic [1:0] stepOf(input logic [SS_W-1:0] count);
		if (count < SS_W'(SS_STEP_CYC))
			stepOf = 2'h0;
		else if (count < SS_W'(2 * SS_STEP_CYC))
			stepOf = 2'h1;
		else if (count < SS_W'(3 * SS_STEP_CYC))
			stepOf = 2'h2;
		else
			stepOf = 2'h3;
	endfunction

	assign filterClr = ~(uvloOk & refOk);
	assign pgBadRaw  = st_r.mSync2[3] | ~pg90Sync;

	// Filtered fault and window comparators, then synchronised-only current and supply levels
	cbs_deglitch u_ov
	(
		.clk_sys     (clk_sys),
		.rst         (rst),
		.levelIn     (senseIn.overVoltage),
		.filterClr   (filterClr),
		.levelSync   (),
		.levelStable (ovStable)
	);
	cbs_deglitch u_uv
	(
		.clk_sys     (clk_sys),
		.rst         (rst),
		.levelIn     (senseIn.underVoltage),
		.filterClr   (filterClr),
		.levelSync   (),
		.levelStable (uvStable)
	);
	cbs_deglitch u_pg
	(
		.clk_sys     (clk_sys),
		.rst         (rst),
		.levelIn     (pgBadRaw),
		.filterClr   (filterClr),
		.levelSync   (),
		.levelStable (pgStable)
	);
	cbs_deglitch u_oc
	(
		.clk_sys     (clk_sys),
		.rst         (rst),
		.levelIn     (senseIn.posOverCurrent),
		.filterClr   (1'b0),
		.levelSync   (ocSync),
		.levelStable ()
	);
	cbs_deglitch u_nc
	(
		.clk_sys     (clk_sys),
		.rst         (rst),
		.levelIn     (senseIn.negOverCurrent),
		.filterClr   (1'b0),
		.levelSync   (ncSync),
		.levelStable ()
	);
	cbs_deglitch u_p9
	(
		.clk_sys     (clk_sys),
		.rst         (rst),
		.levelIn     (st_r.mSync2[5] & st_r.mSync2[4]),
		.filterClr   (1'b0),
		.levelSync   (uvloOk),
		.levelStable ()
	);
	cbs_deglitch u_rf
	(
		.clk_sys     (clk_sys),
		.rst         (rst),
		.levelIn     (senseIn.referenceInputOk),
		.filterClr   (1'b0),
		.levelSync   (refOk),
		.levelStable ()
	);
	cbs_deglitch u_dr
	(
		.clk_sys     (clk_sys),
		.rst         (rst),
		.levelIn     (senseIn.driverSupplyOk),
		.filterClr   (1'b0),
		.levelSync   (drvOk),
		.levelStable ()
	);

	assign pg90Sync = st_r.mSync2[2];
	assign lgOff    = st_r.mSync2[0];
	assign phLow    = st_r.mSync2[1];

	always_comb
	begin
		logic enable;
		logic faultAny;
		logic ssClr;
		logic hsStart;
		logic lowOn;
		enable   = 1'b0;
		lowOn    = 1'b0;
		faultAny = 1'b0;
		ssClr    = 1'b0;
		hsStart  = 1'b0;
		st_nxt   = st_r;

		st_nxt.mSync1   = {senseIn.analogUvloOk, senseIn.analogPor, senseIn.pgWindowOut,
			senseIn.pgNinety, senseIn.phaseLow, senseIn.lowGateOff};
		st_nxt.mSync2   = st_r.mSync1;
		st_nxt.fbSync1  = feedbackLow;
		st_nxt.fbSync2  = st_r.fbSync1;
		st_nxt.tonSync1 = onTimeDone;
		st_nxt.tonSync2 = st_r.tonSync1;
		st_nxt.prevUvloOk = uvloOk;
		st_nxt.prevRefOk  = refOk;

		// Fault latches clear only on supply or reference toggle
		if ((uvloOk && !st_r.prevUvloOk) || (refOk && !st_r.prevRefOk))
		begin
			st_nxt.faultOv = 1'b0;
			st_nxt.faultUv = 1'b0;
		end
		// A fault arriving with the clear still latches
		if (ovStable && uvloOk && refOk)
			st_nxt.faultOv = 1'b1;
		if (uvStable && st_r.ssDone && !st_r.faultOv)
			st_nxt.faultUv = 1'b1;
		faultAny = st_r.faultOv | st_r.faultUv;

		enable = uvloOk & refOk & drvOk;
		ssClr  = ~enable;

		if (ssClr || faultAny)
		begin
			st_nxt.state = CBS_OFF;
			st_nxt.timer = '0;
		end
		else
		begin
			case (st_r.state)
				CBS_OFF:
				begin
					st_nxt.state = CBS_BOOT;
					st_nxt.timer = TIMER_W'(NOC_PROBE_CYC);
				end
				CBS_BOOT:
				begin
					if (st_r.timer != '0)
						st_nxt.timer = st_r.timer - 1'b1;
					else
						st_nxt.state = CBS_LOW;
				end
				CBS_LOW:
				begin
					if (ncSync && !st_r.lowRel)
					begin
						st_nxt.state = CBS_NOCWAIT;
						st_nxt.timer = TIMER_W'(NOC_WAIT_CYC);
					end
					else if (ocSync)
						st_nxt.lowRel = 1'b0;
					else if (!st_r.lowRel)
					begin
						// Release the low side, then let its sensor catch up
						if (st_r.fbSync2)
						begin
							st_nxt.lowRel = 1'b1;
							st_nxt.timer  = TIMER_W'(SENSE_LAG_CYC);
						end
					end
					else if (st_r.timer != '0)
						st_nxt.timer = st_r.timer - 1'b1;
					else if (lgOff)
						hsStart = 1'b1;
				end
				CBS_HIGH:
				begin
					if (st_r.timer != '0)
						st_nxt.timer = st_r.timer - 1'b1;
					else if (st_r.tonSync2)
					begin
						st_nxt.state = CBS_MINOFF;
						st_nxt.timer = minOffFor(st_r.drive.limitStep);
					end
				end
				CBS_MINOFF:
				begin
					if (st_r.timer != '0)
						st_nxt.timer = st_r.timer - 1'b1;
					else if (phLow)
						st_nxt.state = CBS_LOW;
				end
				CBS_NOCWAIT:
				begin
					if (st_r.timer != '0)
						st_nxt.timer = st_r.timer - 1'b1;
					else if (phLow)
					begin
						st_nxt.state = CBS_NOCPROB;
						st_nxt.timer = TIMER_W'(NOC_PROBE_CYC);
					end
				end
				CBS_NOCPROB:
				begin
					if (st_r.timer != '0)
						st_nxt.timer = st_r.timer - 1'b1;
					else if (ncSync)
					begin
						st_nxt.state = CBS_NOCWAIT;
						st_nxt.timer = TIMER_W'(NOC_WAIT_CYC);
					end
					else
						st_nxt.state = CBS_LOW;
				end
				default:
				begin
					st_nxt.state = CBS_OFF;
					st_nxt.timer = '0;
				end
			endcase
		end
		if (hsStart)
		begin
			st_nxt.state = CBS_HIGH;
			st_nxt.timer = TIMER_W'(TON_OFFS_CYC);
		end
		if (st_nxt.state != CBS_LOW)
			st_nxt.lowRel = 1'b0;
		lowOn = (st_nxt.state == CBS_LOW) & ~st_nxt.lowRel;

		// Soft-start counts high-side pulses
		if (ssClr || !st_r.prevUvloOk)
		begin
			st_nxt.ssCount = '0;
			st_nxt.ssDone  = 1'b0;
		end
		else if (hsStart && !st_r.ssDone)
		begin
			if (st_r.ssCount == SS_W'(SS_TOTAL_CYC - 1))
				st_nxt.ssDone = 1'b1;
			st_nxt.ssCount = st_r.ssCount + 1'b1;
		end

		// Outputs
		st_nxt.drive.bufferedReferenceOn = uvloOk & refOk;
		st_nxt.drive.terminationOn = enable & ~faultAny;
		st_nxt.drive.faultOv = st_nxt.faultOv;
		st_nxt.drive.faultUv = st_nxt.faultUv;
		st_nxt.drive.limitStep = st_nxt.ssDone ? 2'h3 : stepOf(st_r.ssCount);
		st_nxt.drive.gateTriState = ~uvloOk | (st_nxt.faultUv & ~st_nxt.faultOv);
		st_nxt.drive.highSideGate = (st_nxt.state == CBS_HIGH) & ~st_nxt.faultOv & ~st_nxt.faultUv;
		st_nxt.drive.lowSideGate  = st_nxt.faultOv ? uvloOk :
			((st_nxt.state == CBS_BOOT) | lowOn | (st_nxt.state == CBS_NOCPROB));
		st_nxt.drive.limitSourceOn = st_nxt.drive.lowSideGate & ~st_nxt.faultOv;
		st_nxt.drive.powerGoodOut = st_r.ssDone & ~pgStable & ~faultAny & enable;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st_r            <= '0;
			st_r.state      <= CBS_OFF;
			st_r.drive.limitStep <= STEP_RST;
			st_r.drive.gateTriState <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign driveOut = st_r.drive;
endmodule

/* File: sim/cbs_fet_model.sv */
// Behavioural switch pair seen through the gate and phase sensors
`timescale 1ns/1ps
module cbs_fet_model
(
	// Clock
	input  wire logic clk_sys,
	// Gate drive and pace
	input  wire logic highGate,
	input  wire logic lowGate,
	input  wire logic triState,
	input  wire logic slow,
	// Sensed levels
	output logic      lowGateOff,
	output logic      phaseLow
);
	logic [2:0] lowHist;
	logic [2:0] highHist;
	always_ff @(posedge clk_sys)
	begin
		lowHist <= {lowHist[1:0], lowGate & ~triState};
		highHist <= {highHist[1:0], highGate & ~triState};
	end
	// Slow gates take three cycles to discharge
	assign lowGateOff = slow ? lowHist == 3'h0 : !lowHist[0];
	assign phaseLow = slow ? highHist == 3'h0 : !highHist[0];
endmodule

/* File: sim/cbs_sequencer_monitor.sv */
// Port assertions for the buck sequencer
`timescale 1ns/1ps
module cbs_sequencer_monitor
	import cbs_pkg::*;
(
	// Clock and reset
	input wire logic                clk_sys,
	input wire logic                rst,
	// Observed ports
	input wire cbs_pkg::cbs_sense_t senseIn,
	input wire logic                feedbackLow,
	input wire logic                onTimeDone,
	input wire cbs_pkg::cbs_drive_t driveOut
);
	int unsigned hiCnt;
	int unsigned ovRun;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			hiCnt <= '0;
			ovRun <= '0;
		end
		else
		begin
			hiCnt <= hiCnt + 32'($rose(driveOut.highSideGate));
			ovRun <= senseIn.overVoltage ? ovRun + 32'h1 : '0;
		end
	end
	default clocking mcb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	sequence ocHeld;
		senseIn.posOverCurrent[*6];
	endsequence
	sequence highEnds;
		$fell(driveOut.highSideGate);
	endsequence
	chk_no_overlap: assert property (!(driveOut.highSideGate && driveOut.lowSideGate))
		else $error("gates overlap");
	chk_min_off: assert property (highEnds |=> (!driveOut.highSideGate)[*4])
		else $error("off-time short");
	chk_oc_withhold: assert property (ocHeld |-> !$rose(driveOut.highSideGate))
		else $error("pulse in over-current");
	chk_limit_source: assert property (driveOut.limitSourceOn |-> driveOut.lowSideGate || $past(driveOut.lowSideGate))
		else $error("source without low gate");
	chk_ov_latch: assert property (driveOut.faultOv && $past(driveOut.faultOv) |-> driveOut.lowSideGate)
		else $error("low gate not latched");
	chk_uv_tri: assert property (driveOut.faultUv && $past(driveOut.faultUv) |-> driveOut.gateTriState)
		else $error("gates not tri-stated");
	chk_pg_soft: assert property ($rose(driveOut.powerGoodOut) |-> hiCnt >= SS_TOTAL_CYC)
		else $error("good before soft start");
	chk_ov_persist: assert property ($rose(driveOut.faultOv) |-> $past(ovRun, 2) >= 45)
		else $error("overvoltage not filtered");
endmodule
bind cbs_sequencer cbs_sequencer_monitor mon (.clk_sys(clk_sys), .rst(rst), .senseIn(senseIn),
	.feedbackLow(feedbackLow), .onTimeDone(onTimeDone), .driveOut(driveOut));

/* File: sim/cbs_sequencer_tb_top.sv */
// Self-checking bench for the buck sequencer
`timescale 1ns/1ps
module cbs_sequencer_tb_top;
	import cbs_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       feedbackLow = 1'b0;
	logic       onTimeDone = 1'b0;
	logic       slowFet = 1'b0;
	logic       lowGateOff;
	logic       phaseLow;
	logic       wasHigh;
	cbs_sense_t sense = '0;
	cbs_sense_t senseIn;
	cbs_drive_t driveOut;
	int         failures = 0;
	int         total_checks = 0;
	int         pulses;
	int         gap;
	int         n;
	initial
	begin
		forever #50 clk_sys = ~clk_sys;
	end
	always_comb
	begin
		senseIn = sense;
		senseIn.lowGateOff = lowGateOff;
		senseIn.phaseLow = phaseLow;
	end
	cbs_sequencer dut (.clk_sys(clk_sys), .rst(rst), .senseIn(senseIn), .feedbackLow(feedbackLow),
		.onTimeDone(onTimeDone), .driveOut(driveOut));
	cbs_fet_model fet (.clk_sys(clk_sys), .highGate(driveOut.highSideGate), .lowGate(driveOut.lowSideGate),
		.triState(driveOut.gateTriState), .slow(slowFet), .lowGateOff(lowGateOff), .phaseLow(phaseLow));
	task automatic close_out();
		if (failures == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic tick(int k);
		repeat (k) @(posedge clk_sys);
		#5;
	endtask
	function automatic logic pick(int s);
		return s == 0 ? driveOut.lowSideGate : s == 1 ? driveOut.highSideGate : driveOut.powerGoodOut;
	endfunction
	// Bounded wait for low gate, high gate or power good
	task automatic wait_for(int s, logic v, int lim);
		n = 0;
		while (pick(s) !== v && n < lim)
		begin
			tick(1);
			n++;
		end
		if (n >= lim)
		begin
			failures++;
			close_out();
		end
	endtask
	// Random switching, model checks at high-side pulses except the first two of each 110-pulse step
	task automatic run_pulses(int target);
		int lim;
		int step;
		lim = 0;
		step = 0;
		pulses = 0;
		gap = 100;
		wasHigh = 1'b0;
		while (pulses < target && lim < 20000)
		begin
			feedbackLow = 1'($urandom_range(1, 0));
			onTimeDone = 1'($urandom_range(1, 0));
			slowFet = 1'($urandom_range(1, 0));
			sense.posOverCurrent = ($urandom_range(15, 0) == 0);
			tick(1);
			lim++;
			if (driveOut.highSideGate === 1'b1)
			begin
				if (!wasHigh && pulses % SS_STEP_CYC > 1)
				begin
					step = pulses / SS_STEP_CYC;
					check("limitStep", (step > 3) ? 3 : step, driveOut.limitStep);
					check("off gap", 1, gap >= ((pulses < SS_STEP_CYC) ? 2 : 1) * MIN_OFF_CYC);
				end
				pulses += !wasHigh;
				gap = 0;
			end
			else
				gap++;
			wasHigh = driveOut.highSideGate;
		end
		if (lim >= 20000)
		begin
			failures++;
			close_out();
		end
		feedbackLow = 1'b0;
		sense.posOverCurrent = 1'b0;
	endtask
	initial
	begin
		void'($urandom(41));
		tick(12);
		check("triState", 1, driveOut.gateTriState);
		rst = 1'b0;
		sense.analogPor = 1'b1;
		sense.analogUvloOk = 1'b1;
		sense.driverSupplyOk = 1'b1;
		sense.referenceInputOk = 1'b1;
		sense.pgNinety = 1'b1;
		wait_for(0, 1'b1, 20);
		check("boot high", 0, driveOut.highSideGate);
		check("reference", 1, driveOut.bufferedReferenceOn);
		check("termination", 1, driveOut.terminationOn);
		check("source", 1, driveOut.limitSourceOn);
		run_pulses(450);
		onTimeDone = 1'b1;
		feedbackLow = 1'b1;
		sense.posOverCurrent = 1'b1;
		tick(30);
		check("high held", 0, driveOut.highSideGate);
		sense.posOverCurrent = 1'b0;
		wait_for(1, 1'b1, 20);
		feedbackLow = 1'b0;
		wait_for(2, 1'b1, 200);
		check("good", 1, driveOut.powerGoodOut);
		sense.pgWindowOut = 1'b1;
		tick(20);
		check("good glitch", 1, driveOut.powerGoodOut);
		tick(60);
		check("good out", 0, driveOut.powerGoodOut);
		sense.pgWindowOut = 1'b0;
		sense.driverSupplyOk = 1'b0;
		tick(10);
		check("suspend term", 0, driveOut.terminationOn);
		check("suspend ref", 1, driveOut.bufferedReferenceOn);
		sense.driverSupplyOk = 1'b1;
		sense.underVoltage = 1'b1;
		tick(80);
		check("uv blanked", 0, driveOut.faultUv);
		sense.underVoltage = 1'b0;
		wait_for(0, 1'b1, 30);
		sense.negOverCurrent = 1'b1;
		wait_for(0, 1'b0, 10);
		check("source off", 0, driveOut.limitSourceOn);
		wait_for(0, 1'b1, 60);
		check("neg wait", 1, n >= NOC_WAIT_CYC - 3 && n <= NOC_WAIT_CYC + 3);
		wait_for(0, 1'b0, 10);
		check("probe", 1, n >= NOC_PROBE_CYC - 1 && n <= NOC_PROBE_CYC + 1);
		sense.negOverCurrent = 1'b0;
		sense.overVoltage = 1'b1;
		tick(20);
		sense.overVoltage = 1'b0;
		tick(5);
		check("ov short", 0, driveOut.faultOv);
		sense.overVoltage = 1'b1;
		tick(80);
		check("ov", 1, driveOut.faultOv);
		check("ov low gate", 1, driveOut.lowSideGate);
		sense.overVoltage = 1'b0;
		tick(100);
		check("ov held", 1, driveOut.faultOv);
		sense.referenceInputOk = 1'b0;
		tick(10);
		sense.referenceInputOk = 1'b1;
		tick(10);
		check("ov cleared", 0, driveOut.faultOv);
		run_pulses(450);
		sense.underVoltage = 1'b1;
		tick(80);
		check("uv", 1, driveOut.faultUv);
		check("uv tri", 1, driveOut.gateTriState);
		sense.underVoltage = 1'b0;
		sense.analogUvloOk = 1'b0;
		tick(10);
		check("lockout ref", 0, driveOut.bufferedReferenceOn);
		sense.analogUvloOk = 1'b1;
		tick(10);
		check("uv cleared", 0, driveOut.faultUv);
		check("ref back", 1, driveOut.bufferedReferenceOn);
		close_out();
	end
endmodule
